// >>> core/spi_status_regs.svh
// Register offsets, field positions and reset values of the serial master
// Contract
// - Foreign select mid-transfer sets collision bit six
// - Status read returns, then clears collision
// - Bit four shows receive FIFO full
// - Bit three shows receive FIFO not empty
// - Bit two shows transmit FIFO empty
// - Bit one shows transmit FIFO not full
// - Bit zero shows transfer in progress
// - Mask register readable, writable, gates all sources
// - Mask zero blocks, one passes interrupt
// - Transmit empty interrupt when level at or below threshold
// - Receive full interrupt when level above threshold
`ifndef SPI_STATUS_REGS_SVH
`define SPI_STATUS_REGS_SVH
`define OFS_CTRL 8'h00
`define OFS_TXTHR 8'h18
`define OFS_RXTHR 8'h1c
`define OFS_TXLVL 8'h20
`define OFS_RXLVL 8'h24
`define OFS_STAT 8'h28
`define OFS_MASK 8'h2c
`define OFS_ISR 8'h30
`define OFS_DATA 8'h60
`define CTRL_EN 0
`define ST_BUSY 0
`define ST_TNF 1
`define ST_TFE 2
`define ST_RNE 3
`define ST_RFF 4
`define ST_COL 6
`define IRQ_TXE 0
`define IRQ_RXF 1
`define IRQ_COL 2
`define IRQ_W 3
`define CNT_W 4
`define DAT_W 8
`define MASK_RST 3'h0
`define THR_RST 4'h0
`define BIT_LAST 3'h7
`endif

// >>> core/spi_pkg.sv
// Types shared by the serial master files
package spi_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_LOAD = 2'h1,
    ST_SHIFT = 2'h3,
    ST_STOP = 2'h2
  } xfer_state_t;
endpackage

// >>> core/spi_fifo_mem.sv
// Small FIFO with registered show-ahead head word
`timescale 1ns/1ps
`default_nettype none
module spi_fifo_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Fill side
  input wire logic push_i,
  input wire logic [WIDTH-1:0] wdata_i,
  // Drain side
  input wire logic pop_i,
  output logic [WIDTH-1:0] head_o,
  // Occupancy
  output logic [3:0] count_o
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [3:0] DEPTH_L = 4'(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

  if (DEPTH < 2 || DEPTH > 15)
    $error("spi_fifo_mem: DEPTH must be 2..15");

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wptr_ff;
  logic [AW-1:0] rptr_ff;
  logic [3:0] count_ff;
  logic [WIDTH-1:0] head_ff;

  wire do_push = push_i && (count_ff != DEPTH_L);
  wire do_pop = pop_i && (count_ff != 4'h0);
  wire [AW-1:0] nxt_wptr = (wptr_ff == LAST) ? '0 : wptr_ff + 1'b1;
  wire [AW-1:0] rptr_inc = (rptr_ff == LAST) ? '0 : rptr_ff + 1'b1;
  wire [AW-1:0] nxt_rptr = do_pop ? rptr_inc : rptr_ff;
  wire [3:0] nxt_count = count_ff + {3'h0, do_push} - {3'h0, do_pop};
  // Bypass keeps the head valid when the written slot is the next head
  wire [WIDTH-1:0] nxt_head = (do_push && wptr_ff == nxt_rptr) ?
                              wdata_i : mem_ff[nxt_rptr];

  always_ff @(posedge clk_i) begin
    if (do_push) begin
      mem_ff[wptr_ff] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      wptr_ff <= '0;
      rptr_ff <= '0;
      count_ff <= 4'h0;
      head_ff <= '0;
    end else begin
      wptr_ff <= do_push ? nxt_wptr : wptr_ff;
      rptr_ff <= nxt_rptr;
      count_ff <= nxt_count;
      head_ff <= nxt_head;
    end
  end

  assign head_o = head_ff;
  assign count_o = count_ff;
endmodule
`default_nettype wire

// >>> core/spi_status_irq.sv
// Serial master with status flags, interrupt mask and sticky interrupts
//
// Design decision made here: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "spi_status_regs.svh"
module spi_status_irq import spi_pkg::*; #(
  parameter int DEPTH = 8,
  parameter int HALF_DIV = 2
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // Serial link
  output logic sclk_o,
  output logic mosi_o,
  output logic ss_n_o,
  input wire logic miso_i,
  input wire logic ss_in_n_i,
  // Interrupt
  output logic irq_o
);
  localparam logic [3:0] DEPTH_L = 4'(DEPTH);
  localparam logic [7:0] HALF_L = 8'(HALF_DIV - 1);

  if (DEPTH < 2 || DEPTH > 15)
    $error("spi_status_irq: DEPTH must be 2..15");
  if (HALF_DIV < 1 || HALF_DIV > 256)
    $error("spi_status_irq: HALF_DIV must be 1..256");

  // Pin synchronisers
  logic miso_s1_ff, miso_s2_ff, ssin_s1_ff, ssin_s2_ff;
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      miso_s1_ff <= 1'b0;
      miso_s2_ff <= 1'b0;
      ssin_s1_ff <= 1'b1;
      ssin_s2_ff <= 1'b1;
    end else begin
      miso_s1_ff <= miso_i;
      miso_s2_ff <= miso_s1_ff;
      ssin_s1_ff <= ss_in_n_i;
      ssin_s2_ff <= ssin_s1_ff;
    end
  end

  // Registers
  logic en_ff;
  logic [3:0] tx_thr_ff, rx_thr_ff;
  logic [`IRQ_W-1:0] mask_ff, isr_ff;
  logic col_ff;
  logic irq_ff;
  logic [31:0] rdata_ff;
  xfer_state_t state_ff, nxt_state;
  logic [7:0] div_ff;
  logic sclk_ff, mosi_ff, ss_n_ff;
  logic [2:0] bit_ff;
  logic [`DAT_W-1:0] sh_ff;

  // Decode
  wire sel_ctrl = addr_i == `OFS_CTRL;
  wire sel_txthr = addr_i == `OFS_TXTHR;
  wire sel_rxthr = addr_i == `OFS_RXTHR;
  wire sel_txlvl = addr_i == `OFS_TXLVL;
  wire sel_rxlvl = addr_i == `OFS_RXLVL;
  wire sel_stat = addr_i == `OFS_STAT;
  wire sel_mask = addr_i == `OFS_MASK;
  wire sel_isr = addr_i == `OFS_ISR;
  wire sel_data = addr_i == `OFS_DATA;
  wire rd_stat = rd_i && sel_stat;
  wire rd_isr = rd_i && sel_isr;

  // FIFOs
  wire [3:0] tx_cnt, rx_cnt;
  wire [`DAT_W-1:0] tx_head, rx_head;
  wire tx_push = wr_i && sel_data;
  wire rx_pop = rd_i && sel_data;
  wire tx_pop, rx_push;

  spi_fifo_mem #(.WIDTH(`DAT_W), .DEPTH(DEPTH)) tx_fifo (
    .clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .push_i(tx_push),
    .wdata_i(wdata_i[`DAT_W-1:0]),
    .pop_i(tx_pop),
    .head_o(tx_head),
    .count_o(tx_cnt)
  );

  spi_fifo_mem #(.WIDTH(`DAT_W), .DEPTH(DEPTH)) rx_fifo (
    .clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .push_i(rx_push),
    .wdata_i({sh_ff[`DAT_W-2:0], miso_s2_ff}),
    .pop_i(rx_pop),
    .head_o(rx_head),
    .count_o(rx_cnt)
  );

  // Status flags
  wire f_busy = state_ff != ST_IDLE;
  wire f_tnf = tx_cnt != DEPTH_L;
  wire f_tfe = tx_cnt == 4'h0;
  wire f_rne = rx_cnt != 4'h0;
  wire f_rff = rx_cnt == DEPTH_L;
  // Collision only counts while this master is mid-transfer
  wire collide = f_busy && !ssin_s2_ff;
  // Reserved status bits stay zero
  wire [31:0] stat_word = {25'h0, col_ff, 1'b0, f_rff, f_rne, f_tfe,
                           f_tnf, f_busy};

  // Interrupt sources
  wire [`IRQ_W-1:0] irq_src;
  assign irq_src[`IRQ_TXE] = tx_cnt <= tx_thr_ff;
  assign irq_src[`IRQ_RXF] = {1'b0, rx_cnt} >=
                             ({1'b0, rx_thr_ff} + 5'h01);
  assign irq_src[`IRQ_COL] = collide;

  // Set beats the clear-on-read
  wire nxt_col = collide || (col_ff && !rd_stat);
  wire [`IRQ_W-1:0] nxt_isr = irq_src | (rd_isr ? '0 : isr_ff);
  wire [`IRQ_W-1:0] nxt_mask = (wr_i && sel_mask) ?
                               wdata_i[`IRQ_W-1:0] : mask_ff;
  wire nxt_irq = |(nxt_isr & nxt_mask);
  wire thr_ok = wdata_i[3:0] < DEPTH_L;

  // Read mux
  wire [31:0] nxt_rdata =
    !rd_i ? 32'h0 :
    sel_ctrl ? {31'h0, en_ff} :
    sel_txthr ? {28'h0, tx_thr_ff} :
    sel_rxthr ? {28'h0, rx_thr_ff} :
    sel_txlvl ? {28'h0, tx_cnt} :
    sel_rxlvl ? {28'h0, rx_cnt} :
    sel_stat ? stat_word :
    sel_mask ? {29'h0, mask_ff} :
    sel_isr ? {29'h0, isr_ff} :
    sel_data ? {24'h0, rx_head} : 32'h0;

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      en_ff <= 1'b0;
      tx_thr_ff <= `THR_RST;
      rx_thr_ff <= `THR_RST;
      mask_ff <= `MASK_RST;
      isr_ff <= '0;
      col_ff <= 1'b0;
      irq_ff <= 1'b0;
      rdata_ff <= 32'h0;
    end else begin
      en_ff <= (wr_i && sel_ctrl) ? wdata_i[`CTRL_EN] : en_ff;
      tx_thr_ff <= (wr_i && sel_txthr && thr_ok) ? wdata_i[3:0] : tx_thr_ff;
      rx_thr_ff <= (wr_i && sel_rxthr && thr_ok) ? wdata_i[3:0] : rx_thr_ff;
      mask_ff <= nxt_mask;
      isr_ff <= nxt_isr;
      col_ff <= nxt_col;
      irq_ff <= nxt_irq;
      rdata_ff <= nxt_rdata;
    end
  end

  // Serial clock enable
  wire tick = div_ff == HALF_L;
  wire last_bit = bit_ff == `BIT_LAST;
  wire start = en_ff && !f_tfe && ssin_s2_ff;
  assign tx_pop = (state_ff == ST_IDLE) && start;
  assign rx_push = (state_ff == ST_SHIFT) && tick && !sclk_ff && last_bit;

  // Transfer sequencer
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (start) begin
          nxt_state = ST_LOAD;
        end
      end
      ST_LOAD: begin
        if (tick) begin
          nxt_state = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (tick && sclk_ff && last_bit) begin
          nxt_state = ST_STOP;
        end
      end
      ST_STOP: begin
        if (tick) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
    if (collide || !en_ff) begin
      nxt_state = ST_IDLE;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      state_ff <= ST_IDLE;
      div_ff <= 8'h0;
    end else begin
      state_ff <= nxt_state;
      div_ff <= (tick || state_ff == ST_IDLE) ? 8'h0 : div_ff + 8'h1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      sclk_ff <= 1'b0;
      mosi_ff <= 1'b0;
      ss_n_ff <= 1'b1;
      bit_ff <= 3'h0;
      sh_ff <= '0;
    end else if (nxt_state == ST_IDLE) begin
      sclk_ff <= 1'b0;
      ss_n_ff <= 1'b1;
      bit_ff <= 3'h0;
    end else if (tx_pop) begin
      ss_n_ff <= 1'b0;
      sh_ff <= tx_head;
      mosi_ff <= tx_head[`DAT_W-1];
    end else if (state_ff == ST_SHIFT && tick) begin
      sclk_ff <= !sclk_ff;
      if (!sclk_ff) begin
        sh_ff <= {sh_ff[`DAT_W-2:0], miso_s2_ff};
      end else begin
        bit_ff <= bit_ff + 3'h1;
        mosi_ff <= sh_ff[`DAT_W-1];
      end
    end
  end

  assign rdata_o = rdata_ff;
  assign sclk_o = sclk_ff;
  assign mosi_o = mosi_ff;
  assign ss_n_o = ss_n_ff;
  assign irq_o = irq_ff;

  // Checks
  a_col_sets: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    collide |=> col_ff)
    else $error("collision flag not set");
  a_col_aborts: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    collide |=> (state_ff == ST_IDLE) && ss_n_o ##1 ss_n_o)
    else $error("transfer not halted on collision");
  a_col_read_clear: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (rd_stat && col_ff && !collide) |=> rdata_o[`ST_COL] && !col_ff)
    else $error("collision read did not return then clear");
  a_rx_full_bit: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    rd_stat |=> rdata_o[`ST_RFF] == ($past(rx_cnt) == DEPTH_L))
    else $error("rx full bit wrong");
  a_rx_ne_bit: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    rd_stat |=> rdata_o[`ST_RNE] == ($past(rx_cnt) != 4'h0))
    else $error("rx not empty bit wrong");
  a_tx_empty_bit: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    rd_stat |=> rdata_o[`ST_TFE] == ($past(tx_cnt) == 4'h0))
    else $error("tx empty bit wrong");
  a_tx_nf_bit: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    rd_stat |=> rdata_o[`ST_TNF] == ($past(tx_cnt) != DEPTH_L))
    else $error("tx not full bit wrong");
  a_busy_bit: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    tx_pop |=> ##1 !(rd_stat) or (rd_stat |=> rdata_o[`ST_BUSY]))
    else $error("busy bit wrong");
  a_mask_write: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (wr_i && sel_mask) ##1 (rd_i && sel_mask) |=>
      rdata_o[`IRQ_W-1:0] == $past(wdata_i[`IRQ_W-1:0], 2))
    else $error("mask readback wrong");
  a_irq_gate: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    irq_o == |(isr_ff & mask_ff))
    else $error("interrupt not gated by mask");
  a_tx_thr_irq: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (tx_cnt <= tx_thr_ff) |=> isr_ff[`IRQ_TXE])
    else $error("tx threshold interrupt missing");
  a_rx_thr_irq: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (rx_cnt > rx_thr_ff) |=> isr_ff[`IRQ_RXF])
    else $error("rx threshold interrupt missing");
  a_reserved_zero: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    rd_stat |=> rdata_o[31:7] == 25'h0 && !rdata_o[5])
    else $error("reserved status bits not zero");
endmodule
`default_nettype wire

// >>> bench/spi_slave_model.sv
// Serial slave and foreign master select for the bench
`timescale 1ns/1ps
`default_nettype none
module spi_slave_model #(
  parameter logic [7:0] REPLY = 8'h3c
) (
  // Serial link
  input wire logic sclk_i,
  input wire logic ss_n_i,
  input wire logic mosi_i,
  output logic miso_o,
  // Foreign master
  input wire logic collide_i,
  output logic ss_in_n_o,
  // Last byte taken in
  output logic [7:0] got_o
);
  logic [7:0] tx_sh = 8'h00;
  logic [7:0] rx_sh = 8'h00;
  initial miso_o = 1'b0;
  initial got_o = 8'h00;
  // Other master selects while told to
  assign ss_in_n_o = ~collide_i;
  always @(negedge ss_n_i) begin
    tx_sh = REPLY;
    miso_o = REPLY[7];
  end
  always @(negedge sclk_i) begin
    if (!ss_n_i) begin
      tx_sh = {tx_sh[6:0], 1'b0};
      miso_o = tx_sh[7];
    end
  end
  always @(posedge sclk_i) begin
    if (!ss_n_i) begin
      rx_sh = {rx_sh[6:0], mosi_i};
    end
  end
  // Released line shows the inverse of its last level
  always @(posedge ss_n_i) begin
    got_o = rx_sh;
    miso_o = ~miso_o;
  end
endmodule
`default_nettype wire

// >>> bench/spi_master_status_and_irq_mask_bench.sv
// Bench for the serial master status and interrupt block
`timescale 1ns/1ps
`default_nettype none
`include "spi_status_regs.svh"
module spi_master_status_and_irq_mask_bench;
  logic ref_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic collide = 1'b0;
  logic [31:0] rdata_o;
  logic [31:0] rv;
  logic sclk_o, mosi_o, ss_n_o, miso, ss_in_n, irq_o;
  logic [7:0] got;
  int fails = 0;
  int cmp_count = 0;
  int cyc = 0;
  always #20 ref_clk_i = ~ref_clk_i;
  spi_status_irq #(.DEPTH(8), .HALF_DIV(4)) u_dut (.ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .sclk_o(sclk_o), .mosi_o(mosi_o),
    .ss_n_o(ss_n_o), .miso_i(miso), .ss_in_n_i(ss_in_n), .irq_o(irq_o));
  spi_slave_model u_peer (.sclk_i(sclk_o), .ss_n_i(ss_n_o),
    .mosi_i(mosi_o), .miso_o(miso), .collide_i(collide),
    .ss_in_n_o(ss_in_n), .got_o(got));
  task automatic chk(input string what, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1 rv = rdata_o;
  endtask
  // Reads status until the masked bits match
  task automatic poll(input logic [31:0] m, exp);
    int n;
    n = 0;
    rd(`OFS_STAT);
    while ((rv & m) !== exp && n < 1000) begin
      rd(`OFS_STAT);
      n++;
    end
  endtask
  task automatic irq_after(input logic [31:0] m, input logic e);
    wr(`OFS_MASK, m);
    repeat (3) @(posedge ref_clk_i);
    chk("irq", {31'h0, irq_o}, {31'h0, e});
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails = fails + 1;
      report_and_stop();
    end
  end
  initial begin
    repeat (12) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    rd(`OFS_STAT);
    chk("status", rv, 32'h6);
    rd(8'h04);
    chk("unmapped", rv, 32'h0);
    chk("irq", {31'h0, irq_o}, 32'h0);
    $display("test reset done");
    wr(`OFS_MASK, 32'h7);
    rd(`OFS_MASK);
    chk("mask", rv, 32'h7);
    @(posedge ref_clk_i);
    addr_i <= `OFS_MASK;
    wdata_i <= 32'h5;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1 chk("mask", rdata_o, 32'h5);
    irq_after(32'h2, 1'b0);
    irq_after(32'h1, 1'b1);
    irq_after(32'h0, 1'b0);
    $display("test mask done");
    wr(`OFS_CTRL, 32'h1);
    wr(`OFS_DATA, 32'ha5);
    poll(32'h1, 32'h1);
    chk("busy", rv & 32'h1, 32'h1);
    poll(32'h1, 32'h0);
    chk("status", rv, 32'he);
    chk("sent", {24'h0, got}, 32'ha5);
    rd(`OFS_ISR);
    chk("isr", rv, 32'h3);
    rd(`OFS_DATA);
    chk("rx data", rv, 32'h3c);
    rd(`OFS_STAT);
    chk("status", rv, 32'h6);
    $display("test transfer done");
    wr(`OFS_CTRL, 32'h0);
    for (int i = 0; i < 8; i++) begin
      wr(`OFS_DATA, i);
    end
    rd(`OFS_STAT);
    chk("status", rv, 32'h0);
    wr(`OFS_CTRL, 32'h1);
    poll(32'hff, 32'h1e);
    chk("status", rv, 32'h1e);
    chk("sent", {24'h0, got}, 32'h7);
    $display("test fill done");
    wr(`OFS_DATA, 32'h55);
    poll(32'h1, 32'h1);
    @(posedge ref_clk_i);
    collide <= 1'b1;
    repeat (8) @(posedge ref_clk_i);
    chk("select", {31'h0, ss_n_o}, 32'h1);
    rd(`OFS_STAT);
    chk("status", rv, 32'h5e);
    rd(`OFS_STAT);
    chk("status", rv, 32'h1e);
    wr(`OFS_STAT, 32'hffffffff);
    rd(`OFS_STAT);
    chk("status", rv, 32'h1e);
    rd(`OFS_ISR);
    chk("isr", rv, 32'h7);
    @(posedge ref_clk_i);
    collide <= 1'b0;
    $display("test collision done");
    report_and_stop();
  end
endmodule
`default_nettype wire
